// >>> design/uesv_cfg.svh
// Offsets, field layouts, reset values of the uncorrectable severity bank.
// Assumes a 12-bit register window decoded from the low AHB address bits.
`ifndef UESV_CFG_SVH
`define UESV_CFG_SVH

`define UESV_SEV_OFFSET 12'h10c
`define UESV_IRQ_STATUS_OFFSET 12'h180
`define UESV_IRQ_CLEAR_OFFSET 12'h184
`define UESV_IRQ_ENABLE_OFFSET 12'h188
`define UESV_LAST_EVENT_OFFSET 12'h18c
`define UESV_FATAL_COUNT_OFFSET 12'h190
`define UESV_NONFATAL_COUNT_OFFSET 12'h194

`define UESV_SEV_RESET 32'h0006_2030
`define UESV_SEV_WRITABLE 32'h803f_3031
`define UESV_REPORTABLE 32'h803f_f030
`define UESV_DBE_BIT 31

`define UESV_IRQ_FATAL_BIT 0
`define UESV_IRQ_NONFATAL_BIT 1
`define UESV_IRQ_W 2

`define UESV_HTRANS_ACTIVE_BIT 1
`define UESV_HSIZE_WORD 3'h2
`define UESV_DECODE_W 12

`endif

// >>> design/uesv_classify.sv
// Per-event severity split of unmasked uncorrectable events.
// Assumes event, mask and enable inputs share the core clock.
`timescale 1ns/1ps
`include "uesv_cfg.svh"

module uesv_classify #(
    parameter int NUM_EVENTS = 32
) (
    // Event sources
    input wire logic [NUM_EVENTS-1:0] event_vec,
    input wire logic [NUM_EVENTS-1:0] mask_vec,
    input wire logic [NUM_EVENTS-1:0] severity_vec,
    input wire logic dbe_enable,
    // Classified hits
    output logic [NUM_EVENTS-1:0] fatal_vec,
    output logic [NUM_EVENTS-1:0] nonfatal_vec
);

    localparam logic [31:0] REPORTABLE = `UESV_REPORTABLE;

    initial begin
        if (NUM_EVENTS != 32) begin
            $error("uesv_classify serves exactly 32 events");
        end
    end

    genvar i;
    generate
        for (i = 0; i < NUM_EVENTS; i++) begin : g_evt
            logic live;
            // Obsolete and reserved positions never report
            if (i == `UESV_DBE_BIT) begin : g_dbe
                assign live = event_vec[i] & ~mask_vec[i] & REPORTABLE[i] & dbe_enable;
            end else begin : g_plain
                assign live = event_vec[i] & ~mask_vec[i] & REPORTABLE[i];
            end
            assign fatal_vec[i] = live & severity_vec[i];
            assign nonfatal_vec[i] = live & ~severity_vec[i];
        end
    endgenerate

endmodule // uesv_classify

// >>> design/uesv_pkg.sv
// Types shared by the uncorrectable severity bank, its checker and the report model.
// Assumes uesv_cfg.svh is included first for the widths used here.
`include "uesv_cfg.svh"

package uesv_pkg;

    typedef struct packed {
        logic fatal;
        logic nonfatal;
    } uesv_report_t;

    typedef enum logic [6:0] {
        UESV_SEL_NONE     = 7'h00,
        UESV_SEL_SEV      = 7'h01,
        UESV_SEL_STATUS   = 7'h02,
        UESV_SEL_CLEAR    = 7'h04,
        UESV_SEL_ENABLE   = 7'h08,
        UESV_SEL_LAST     = 7'h10,
        UESV_SEL_FCOUNT   = 7'h20,
        UESV_SEL_NFCOUNT  = 7'h40
    } uesv_sel_t;

    typedef struct packed {
        logic [31:0] severity;
        logic [`UESV_IRQ_W-1:0] irq_status;
        logic [`UESV_IRQ_W-1:0] irq_enable;
        logic [31:0] last_event;
        logic [15:0] fatal_count;
        logic [15:0] nonfatal_count;
        logic dp_valid;
        logic dp_write;
        logic [`UESV_DECODE_W-1:0] dp_addr;
        logic [31:0] rdata;
        uesv_report_t report;
        logic [31:0] report_vec;
    } uesv_state_t;

endpackage

// >>> design/uesv_top.sv
// Uncorrectable error severity bank of one switch port, with AHB-Lite access.
// Assumes events, mask and double-bit enable come from logic on CORE_CLK.
// RST is the fundamental reset; HOT_RST covers hot and warm resets.
//
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "uesv_cfg.svh"

// Behaviour
// - Unmasked event on a reportable bit with severity one reports fatal
// - Unmasked event on a reportable bit with severity zero reports non-fatal
// - Masked events produce no report
// - Bit 14 read-only, always zero
// - Bit 15 read-only, always zero
// - Bit 31 writable and visible only with enable
// - Bits 4, 5 read-write, reset one
// - Bits 13, 17, 18 read-write, reset one
// - Bits 12, 16, 19-21 read-write, reset zero
// - Bit 0 stored only, no reporting effect
module uesv_top #(
    parameter int ADDR_W = 32,
    parameter int NUM_EVENTS = 32
) (
    // Clock, resets, enable
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic HOT_RST,
    input wire logic CE,
    // AHB-Lite slave
    input wire logic HSEL,
    input wire logic [ADDR_W-1:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // Error sources from the port
    input wire logic [NUM_EVENTS-1:0] UE_EVENT,
    input wire logic [NUM_EVENTS-1:0] UE_MASK,
    input wire logic DBE_REPORT_EN,
    // Reports toward the root complex messaging
    output uesv_pkg::uesv_report_t ERR_REPORT,
    output logic [NUM_EVENTS-1:0] ERR_VECTOR,
    // Interrupt
    output logic IRQ
);

    localparam logic [31:0] SEV_WRITABLE = `UESV_SEV_WRITABLE;
    localparam logic [31:0] SEV_RESET = `UESV_SEV_RESET;
    localparam logic [15:0] COUNT_MAX = 16'hffff;

    localparam uesv_pkg::uesv_state_t RESET_STATE = '{
        severity: SEV_RESET,
        default: '0
    };

    initial begin
        if (ADDR_W < `UESV_DECODE_W) begin
            $error("uesv_top needs at least 12 address bits");
        end
        if (NUM_EVENTS != 32) begin
            $error("uesv_top serves exactly 32 events");
        end
    end

    // Register select from the low address bits
    function automatic uesv_pkg::uesv_sel_t decode(input logic [`UESV_DECODE_W-1:0] addr);
        uesv_pkg::uesv_sel_t sel;
        sel = uesv_pkg::UESV_SEL_NONE;
        case (addr)
            `UESV_SEV_OFFSET: begin
                sel = uesv_pkg::UESV_SEL_SEV;
            end
            `UESV_IRQ_STATUS_OFFSET: begin
                sel = uesv_pkg::UESV_SEL_STATUS;
            end
            `UESV_IRQ_CLEAR_OFFSET: begin
                sel = uesv_pkg::UESV_SEL_CLEAR;
            end
            `UESV_IRQ_ENABLE_OFFSET: begin
                sel = uesv_pkg::UESV_SEL_ENABLE;
            end
            `UESV_LAST_EVENT_OFFSET: begin
                sel = uesv_pkg::UESV_SEL_LAST;
            end
            `UESV_FATAL_COUNT_OFFSET: begin
                sel = uesv_pkg::UESV_SEL_FCOUNT;
            end
            `UESV_NONFATAL_COUNT_OFFSET: begin
                sel = uesv_pkg::UESV_SEL_NFCOUNT;
            end
            default: begin
                sel = uesv_pkg::UESV_SEL_NONE;
            end
        endcase
        return sel;
    endfunction

    // Software view of the severity word
    function automatic logic [31:0] sev_view(input logic [31:0] sev, input logic dbe_en);
        logic [31:0] v;
        v = sev & SEV_WRITABLE;
        v[`UESV_DBE_BIT] = sev[`UESV_DBE_BIT] & dbe_en;
        return v;
    endfunction

    function automatic logic [15:0] sat_inc(input logic [15:0] c);
        return (c == COUNT_MAX) ? c : c + 16'h0001;
    endfunction

    uesv_pkg::uesv_state_t s_q;
    uesv_pkg::uesv_state_t s_d;

    logic [NUM_EVENTS-1:0] fatal_hits;
    logic [NUM_EVENTS-1:0] nonfatal_hits;
    logic [31:0] sev_effective;

    // Stored bit 31 is kept while the enable is low but steers nothing
    assign sev_effective = sev_view(s_q.severity, DBE_REPORT_EN);

    uesv_classify #(
        .NUM_EVENTS(NUM_EVENTS)
    ) u_classify (
        .event_vec(UE_EVENT),
        .mask_vec(UE_MASK),
        .severity_vec(sev_effective),
        .dbe_enable(DBE_REPORT_EN),
        .fatal_vec(fatal_hits),
        .nonfatal_vec(nonfatal_hits)
    );

    always_comb begin
        logic a_valid;
        logic wr_ok;
        logic any_fatal;
        logic any_nonfatal;
        logic [`UESV_IRQ_W-1:0] clr;
        logic [`UESV_IRQ_W-1:0] set;
        logic [31:0] merged;
        uesv_pkg::uesv_state_t hot;
        uesv_pkg::uesv_sel_t rsel;

        a_valid = 1'b0;
        wr_ok = 1'b0;
        any_fatal = 1'b0;
        any_nonfatal = 1'b0;
        clr = '0;
        set = '0;
        merged = '0;
        hot = RESET_STATE;
        rsel = uesv_pkg::UESV_SEL_NONE;
        s_d = s_q;

        // Data phase of a write; non-word sizes are dropped
        wr_ok = s_q.dp_valid & s_q.dp_write;
        if (wr_ok) begin
            unique case (decode(s_q.dp_addr))
                uesv_pkg::UESV_SEL_SEV: begin
                    merged = (s_q.severity & ~SEV_WRITABLE) | (HWDATA & SEV_WRITABLE);
                    if (!DBE_REPORT_EN) begin
                        merged[`UESV_DBE_BIT] = s_q.severity[`UESV_DBE_BIT];
                    end
                    s_d.severity = merged;
                end
                uesv_pkg::UESV_SEL_CLEAR: begin
                    clr = HWDATA[`UESV_IRQ_W-1:0];
                end
                uesv_pkg::UESV_SEL_ENABLE: begin
                    s_d.irq_enable = HWDATA[`UESV_IRQ_W-1:0];
                end
                uesv_pkg::UESV_SEL_STATUS,
                uesv_pkg::UESV_SEL_LAST,
                uesv_pkg::UESV_SEL_FCOUNT,
                uesv_pkg::UESV_SEL_NFCOUNT,
                uesv_pkg::UESV_SEL_NONE: begin
                    s_d.severity = s_q.severity;
                end
            endcase
        end

        // Reports leave one cycle after the event
        any_fatal = |fatal_hits;
        any_nonfatal = |nonfatal_hits;
        s_d.report.fatal = any_fatal;
        s_d.report.nonfatal = any_nonfatal;
        s_d.report_vec = fatal_hits | nonfatal_hits;
        if (any_fatal | any_nonfatal) begin
            s_d.last_event = fatal_hits | nonfatal_hits;
        end
        if (any_fatal) begin
            s_d.fatal_count = sat_inc(s_q.fatal_count);
        end
        if (any_nonfatal) begin
            s_d.nonfatal_count = sat_inc(s_q.nonfatal_count);
        end

        // Sticky status: a new event wins over a clear in the same cycle
        set[`UESV_IRQ_FATAL_BIT] = any_fatal;
        set[`UESV_IRQ_NONFATAL_BIT] = any_nonfatal;
        s_d.irq_status = (s_q.irq_status & ~clr) | set;

        // Address phase
        a_valid = HSEL & HREADY & HTRANS[`UESV_HTRANS_ACTIVE_BIT];
        s_d.dp_valid = a_valid & (HSIZE == `UESV_HSIZE_WORD);
        s_d.dp_write = HWRITE;
        s_d.dp_addr = HADDR[`UESV_DECODE_W-1:0];

        // Read data from the next state, so a read right after a write sees it
        s_d.rdata = '0;
        if (a_valid && !HWRITE) begin
            rsel = decode(HADDR[`UESV_DECODE_W-1:0]);
            unique case (rsel)
                uesv_pkg::UESV_SEL_SEV: begin
                    s_d.rdata = sev_view(s_d.severity, DBE_REPORT_EN);
                end
                uesv_pkg::UESV_SEL_STATUS: begin
                    s_d.rdata = {{(32-`UESV_IRQ_W){1'b0}}, s_d.irq_status};
                end
                uesv_pkg::UESV_SEL_ENABLE: begin
                    s_d.rdata = {{(32-`UESV_IRQ_W){1'b0}}, s_d.irq_enable};
                end
                uesv_pkg::UESV_SEL_LAST: begin
                    s_d.rdata = s_d.last_event;
                end
                uesv_pkg::UESV_SEL_FCOUNT: begin
                    s_d.rdata = {16'h0000, s_d.fatal_count};
                end
                uesv_pkg::UESV_SEL_NFCOUNT: begin
                    s_d.rdata = {16'h0000, s_d.nonfatal_count};
                end
                uesv_pkg::UESV_SEL_CLEAR,
                uesv_pkg::UESV_SEL_NONE: begin
                    s_d.rdata = '0;
                end
            endcase
        end

        // Hot or warm reset clears all but the sticky severity word
        if (HOT_RST) begin
            hot.severity = s_d.severity;
            s_d = hot;
        end
    end

    // Only the fundamental reset restores severity defaults
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            s_q <= RESET_STATE;
        end else if (CE) begin
            s_q <= s_d;
        end
    end

    assign HRDATA = s_q.rdata;
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign ERR_REPORT = s_q.report;
    assign ERR_VECTOR = s_q.report_vec;
    assign IRQ = |(s_q.irq_status & s_q.irq_enable);

endmodule // uesv_top

// >>> testbench/tb_top.sv
// Self-checking bench of the severity bank over AHB-Lite.
// Assumes a zero-wait slave; the model tallies reports.
`timescale 1ns/1ps
module tb_top;
    logic CORE_CLK = 0, RST = 1, HOT_RST = 0, CE = 1, HWRITE = 0, DBE_REPORT_EN = 0, HREADYOUT, HRESP, IRQ;
    logic [31:0] nf, nn;
    logic [1:0] HTRANS = 2'h0;
    logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, UE_EVENT = 32'h0, UE_MASK = 32'h0, HRDATA, ERR_VECTOR, rd, lv;
    uesv_pkg::uesv_report_t ERR_REPORT;
    int n_mismatch = 0, checks_done = 0, cyc = 0;
    always #4 CORE_CLK = ~CORE_CLK;
    uesv_top dut (.CORE_CLK, .RST, .HOT_RST, .CE, .HSEL(1'b1), .HADDR, .HTRANS, .HWRITE, .HSIZE(3'h2),
        .HWDATA, .HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP, .UE_EVENT, .UE_MASK, .DBE_REPORT_EN,
        .ERR_REPORT, .ERR_VECTOR, .IRQ);
    uesv_rc_model rc (.clk(CORE_CLK), .rst(RST), .report(ERR_REPORT), .vec(ERR_VECTOR), .n_fatal(nf),
        .n_nonfatal(nn), .last_vec(lv));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task end_sim;
        if (n_mismatch == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        HADDR <= {20'h0, a};
        HWRITE <= w;
        HTRANS <= 2'h2;
        do @(posedge CORE_CLK); while (HREADYOUT !== 1'b1);
        HTRANS <= 2'h0;
        HWDATA <= d;
        do @(posedge CORE_CLK); while (HREADYOUT !== 1'b1);
        rd = HRDATA;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task rdchk(input logic [11:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    // Pulse events, then compare class tallies
    task ev(input logic [31:0] e, input int ef, input int en);
        logic [31:0] f0, n0;
        f0 = nf;
        n0 = nn;
        UE_EVENT <= e;
        @(posedge CORE_CLK);
        UE_EVENT <= 32'h0;
        repeat (2) @(posedge CORE_CLK);
        chk(nf - f0, ef);
        chk(nn - n0, en);
    endtask
    task t_regs;
        rdchk(12'h10c, 32'h0006_2030);
        wr(12'h10c, 32'hffff_ffff);
        rdchk(12'h10c, 32'h003f_3031);
        DBE_REPORT_EN <= 1'b1;
        wr(12'h10c, 32'hffff_ffff);
        rdchk(12'h10c, 32'h803f_3031);
        rdchk(12'h200, 32'h0);
    endtask
    task t_sticky;
        wr(12'h10c, 32'h0000_0001);
        HOT_RST <= 1'b1;
        @(posedge CORE_CLK);
        HOT_RST <= 1'b0;
        rdchk(12'h10c, 32'h0000_0001);
        RST <= 1'b1;
        DBE_REPORT_EN <= 1'b0;
        @(posedge CORE_CLK);
        RST <= 1'b0;
        rdchk(12'h10c, 32'h0006_2030);
    endtask
    task t_events;
        ev(32'h0000_0010, 1, 0);
        ev(32'h0000_1000, 0, 1);
        // Bits 14 and 15 carry severity zero, so they report non-fatal
        ev(32'h8000_c00f, 0, 1);
        chk(lv, 32'h0000_c000);
        UE_MASK <= 32'h10;
        ev(32'h0000_0010, 0, 0);
        UE_MASK <= 32'h0;
        wr(12'h10c, 32'h0006_3020);
        ev(32'h0000_1010, 1, 1);
        DBE_REPORT_EN <= 1'b1;
        wr(12'h10c, 32'h8000_0000);
        ev(32'h8000_0000, 1, 0);
        chk(lv, 32'h8000_0000);
        DBE_REPORT_EN <= 1'b0;
        ev(32'h8000_0000, 0, 0);
    endtask
    // Status is sticky; enable only gates the level output
    task t_irq;
        wr(12'h184, 32'h3);
        wr(12'h188, 32'h2);
        ev(32'h0000_0010, 0, 1);
        chk({31'h0, IRQ}, 32'h1);
        wr(12'h188, 32'h0);
        rdchk(12'h180, 32'h2);
        chk({31'h0, IRQ}, 32'h0);
        wr(12'h188, 32'h2);
        wr(12'h184, 32'h2);
        rdchk(12'h180, 32'h0);
        chk({31'h0, IRQ}, 32'h0);
        // A frozen block takes no event
        CE <= 1'b0;
        ev(32'h0000_0010, 0, 0);
        CE <= 1'b1;
        rdchk(12'h18c, 32'h0000_0010);
        rdchk(12'h190, 32'h0000_0003);
        rdchk(12'h194, 32'h0000_0004);
    endtask
    always @(posedge CORE_CLK) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_mismatch++;
            end_sim;
        end
    end
    initial begin
        repeat (2) @(posedge CORE_CLK);
        RST <= 1'b0;
        t_regs;
        t_sticky;
        t_events;
        t_irq;
        end_sim;
    end
endmodule // tb_top

// >>> testbench/uesv_chk_assertions.sv
// Port checker of the uncorrectable severity bank.
// Assumes one clock domain; bound into every uesv_top below.
`timescale 1ns/1ps
module uesv_chk #(
    parameter int ADDR_W = 32
) (
    // Clock, reset, bus
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic HSEL,
    input wire logic [ADDR_W-1:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    // Events and reports
    input wire logic [31:0] UE_EVENT,
    input wire logic [31:0] UE_MASK,
    input wire logic DBE_REPORT_EN,
    input wire uesv_pkg::uesv_report_t ERR_REPORT,
    input wire logic [31:0] ERR_VECTOR,
    input wire logic IRQ
);
    // Reserved and hardwired positions
    localparam logic [31:0] quiet_bits = 32'h7fc0_cfce;
    logic sev_rd;
    assign sev_rd = CE && HSEL && HREADY && HTRANS[1] && !HWRITE && HSIZE == 3'h2 && HADDR[11:0] == 12'h10c;
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    a_masked_silent: assert property ($past(CE) |-> (ERR_VECTOR & ~$past(UE_EVENT & ~UE_MASK)) == 32'h0)
        else $error("report without unmasked event");
    // Bits 14 and 15 only read zero; their events still report by severity zero
    a_ro_silent: assert property ((ERR_VECTOR & ((quiet_bits & ~32'h0000_c000) | 32'h1)) == 32'h0)
        else $error("report on quiet bit");
    a_report_match: assert property ((|ERR_VECTOR) == (ERR_REPORT.fatal || ERR_REPORT.nonfatal))
        else $error("vector and report disagree");
    a_single_class: assert property ($onehot(ERR_VECTOR) |-> ERR_REPORT.fatal != ERR_REPORT.nonfatal)
        else $error("one event, wrong class count");
    a_dbe_gated: assert property ($past(CE) && ERR_VECTOR[31] |-> $past(DBE_REPORT_EN))
        else $error("bit 31 reported while disabled");
    a_sev_read_quiet: assert property ($past(sev_rd) |-> (HRDATA & quiet_bits) == 32'h0)
        else $error("quiet bit read nonzero");
    a_dbe_read_zero: assert property ($past(sev_rd && !DBE_REPORT_EN) |-> !HRDATA[31])
        else $error("bit 31 visible while disabled");
    a_bus_okay: assert property (HREADYOUT && !HRESP)
        else $error("bus wait or error");
    c_fatal: cover property (ERR_REPORT.fatal);
    c_nonfatal: cover property (ERR_REPORT.nonfatal);
    c_irq: cover property ($rose(IRQ));
endmodule // uesv_chk

bind uesv_top uesv_chk #(.ADDR_W(ADDR_W)) u_chk (.CORE_CLK, .RST, .CE, .HSEL, .HADDR, .HTRANS, .HWRITE,
    .HSIZE, .HREADY, .HRDATA, .HREADYOUT, .HRESP, .UE_EVENT, .UE_MASK, .DBE_REPORT_EN, .ERR_REPORT,
    .ERR_VECTOR, .IRQ);

// >>> testbench/uesv_rc_model.sv
// Receiver of error reports: counts each class, keeps the last vector.
// Assumes one-cycle report pulses on clk.
`timescale 1ns/1ps
module uesv_rc_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Reports in
    input wire uesv_pkg::uesv_report_t report,
    input wire logic [31:0] vec,
    // Tallies
    output logic [31:0] n_fatal,
    output logic [31:0] n_nonfatal,
    output logic [31:0] last_vec
);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            n_fatal <= 32'h0;
            n_nonfatal <= 32'h0;
            last_vec <= 32'h0;
        end else begin
            // Four-state sums, so an unknown report shows up in the tally
            n_fatal <= n_fatal + {31'h0, report.fatal};
            n_nonfatal <= n_nonfatal + {31'h0, report.nonfatal};
            if (|vec) begin
                last_vec <= vec;
            end
        end
    end
endmodule // uesv_rc_model
